//--- ilo_pkg.sv
// Constants for the input current limit override block.
// Assumes one system clock; imported by the calculator, the override and the bench, but not by the interface.
package ilo_pkg;
    // **********************************************************
    // Register map
    // **********************************************************
    localparam logic [7:0] ILO_STATUS_ADDR = 8'h0d;
    localparam logic [7:0] ILO_CTRL_ADDR = 8'h0e;
    localparam logic [7:0] ILO_CTRL_RESET = 8'h00;
    localparam logic [7:0] ILO_CTRL_WMASK = 8'h0f;
    localparam logic [7:0] ILO_RDATA_IDLE = 8'h00;
    // Control field positions
    localparam int ILO_HOLD_BIT = 0;
    localparam int ILO_SDP_LSB = 1;
    localparam int ILO_SDP_MSB = 2;
    localparam int ILO_CDP_BIT = 3;
    // **********************************************************
    // Charger types and limit codes
    // **********************************************************
    localparam logic [1:0] ILO_TYPE_SDP = 2'h1;
    localparam logic [1:0] ILO_TYPE_CDP = 2'h2;
    localparam logic [1:0] ILO_SDP_OFF = 2'h0;
    localparam logic [1:0] ILO_SDP_500MA = 2'h1;
    localparam logic [1:0] ILO_SDP_1A0 = 2'h2;
    localparam logic [1:0] ILO_SDP_1A5 = 2'h3;
    localparam logic [6:0] ILO_CODE_500MA = 7'h0f;
    localparam logic [6:0] ILO_CODE_1A0 = 7'h1e;
    localparam logic [6:0] ILO_CODE_1A5 = 7'h2d;
    localparam logic [6:0] ILO_CODE_RESET = 7'h00;
    localparam int ILO_CODE_W = 7;
endpackage

//--- ilo_calc_if.sv
// Carrier between the override top and its limit calculator.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface ilo_calc_if;
    logic [6:0] base_code;
    logic [1:0] chg_type;
    logic cdp_cap;
    logic [1:0] sdp_sel;
    logic [6:0] result_code;
    modport calc (input base_code, chg_type, cdp_cap, sdp_sel,
        output result_code);
    modport top (output base_code, chg_type, cdp_cap, sdp_sel,
        input result_code);
endinterface

//--- ilo_limit_calc.sv
// Combinational limit rewrite from charger type and cap fields.
// Assumes inputs are stable registered values on the system clock.
`timescale 1ns/1ns
module ilo_limit_calc
    import ilo_pkg::*;
(
    ilo_calc_if.calc cif
);
    // **********************************************************
    // Override selection
    // **********************************************************
    // Charging port cap takes precedence over the standard cap
    always_comb begin
        cif.result_code = cif.base_code;
        if (cif.cdp_cap && cif.chg_type >= ILO_TYPE_CDP) begin
            cif.result_code = ILO_CODE_1A5;
        end else if (cif.chg_type >= ILO_TYPE_SDP) begin
            case (cif.sdp_sel)
                ILO_SDP_500MA: cif.result_code = ILO_CODE_500MA;
                ILO_SDP_1A0: cif.result_code = ILO_CODE_1A0;
                ILO_SDP_1A5: cif.result_code = ILO_CODE_1A5;
                default: cif.result_code = cif.base_code;
            endcase
        end
    end
endmodule

//--- ilo_override.sv
// Input current limit override: control register and limit output.
// Assumes register port and detection signals share core_clk.
`timescale 1ns/1ns
module ilo_override
    import ilo_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [6:0] base_limit_code,
    input wire logic [1:0] detected_charger_type,
    input wire logic [2:0] prior_charger_type,
    input wire logic detection_running,
    output logic [6:0] input_current_limit_code
);
    // Prior type input is not read by any logic, so it is unused
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] rdata_q, rdata_d;
    logic [6:0] code_q, code_d;
    logic hold;
    ilo_calc_if cif ();

    // **********************************************************
    // Register port
    // **********************************************************
    // Control write and registered read answer
    always_comb begin
        ctrl_d = ctrl_q;
        rdata_d = ILO_RDATA_IDLE;
        if (reg_wr && reg_addr == ILO_CTRL_ADDR) begin
            ctrl_d = reg_wdata & ILO_CTRL_WMASK;
        end
        if (reg_rd) begin
            case (reg_addr)
                ILO_CTRL_ADDR: rdata_d = ctrl_q;
                ILO_STATUS_ADDR: rdata_d = {1'b0, code_q};
                default: rdata_d = ILO_RDATA_IDLE;
            endcase
        end
    end

    // Register state
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= ILO_CTRL_RESET;
            rdata_q <= ILO_RDATA_IDLE;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // **********************************************************
    // Limit calculation
    // **********************************************************
    // Feed calculator from control fields and detection
    assign cif.base_code = base_limit_code;
    assign cif.chg_type = detected_charger_type;
    assign cif.cdp_cap = ctrl_q[ILO_CDP_BIT];
    assign cif.sdp_sel = ctrl_q[ILO_SDP_MSB:ILO_SDP_LSB];

    ilo_limit_calc u_calc (
        .cif(cif)
    );

    // Hold gate and output code update
    always_comb begin
        hold = ctrl_q[ILO_HOLD_BIT] && detection_running;
        code_d = code_q;
        if (!hold) begin
            code_d = cif.result_code;
        end
    end

    // Output code register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            code_q <= ILO_CODE_RESET;
        end else begin
            code_q <= code_d;
        end
    end

    assign input_current_limit_code = code_q;

    // **********************************************************
    // Checks
    // **********************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_free;
        !(ctrl_q[ILO_HOLD_BIT] && detection_running);
    endsequence

    sequence s_sdp;
        detected_charger_type >= ILO_TYPE_SDP
            && !(ctrl_q[ILO_CDP_BIT]
            && detected_charger_type >= ILO_TYPE_CDP);
    endsequence

    chk_cdp_cap_force: assert property (
        s_free and (ctrl_q[ILO_CDP_BIT]
            && detected_charger_type >= ILO_TYPE_CDP)
        |=> input_current_limit_code == ILO_CODE_1A5)
        else $error("charging port cap not applied");

    chk_cdp_cap_off: assert property (
        s_free and (!ctrl_q[ILO_CDP_BIT]
            && detected_charger_type == ILO_TYPE_CDP
            && ctrl_q[ILO_SDP_MSB:ILO_SDP_LSB] == ILO_SDP_OFF)
        |=> input_current_limit_code == $past(base_limit_code))
        else $error("charging port code modified");

    chk_sdp_none: assert property (
        s_free and (ctrl_q[ILO_SDP_MSB:ILO_SDP_LSB] == ILO_SDP_OFF
            && !ctrl_q[ILO_CDP_BIT])
        |=> input_current_limit_code == $past(base_limit_code))
        else $error("standard port code modified");

    chk_sdp_500ma: assert property (
        s_free and s_sdp
            and (ctrl_q[ILO_SDP_MSB:ILO_SDP_LSB] == ILO_SDP_500MA)
        |=> input_current_limit_code == ILO_CODE_500MA)
        else $error("500mA cap wrong");

    chk_sdp_1a0: assert property (
        s_free and s_sdp
            and (ctrl_q[ILO_SDP_MSB:ILO_SDP_LSB] == ILO_SDP_1A0)
        |=> input_current_limit_code == ILO_CODE_1A0)
        else $error("1.0A cap wrong");

    chk_sdp_1a5: assert property (
        s_free and s_sdp
            and (ctrl_q[ILO_SDP_MSB:ILO_SDP_LSB] == ILO_SDP_1A5)
        |=> input_current_limit_code == ILO_CODE_1A5)
        else $error("1.5A cap wrong");

    chk_hold_freeze: assert property (
        ctrl_q[ILO_HOLD_BIT] && detection_running
        |=> $stable(input_current_limit_code))
        else $error("code changed during hold");

    chk_hold_pass: assert property (
        !ctrl_q[ILO_HOLD_BIT] && $changed(base_limit_code)
            && detected_charger_type < ILO_TYPE_SDP
        |=> input_current_limit_code == $past(base_limit_code))
        else $error("change not passed through");

    chk_status_read: assert property (
        reg_rd && reg_addr == ILO_STATUS_ADDR
        |=> reg_rdata == {1'b0, $past(input_current_limit_code)})
        else $error("status read mismatch");

    chk_ctrl_write: assert property (
        reg_wr && reg_addr == ILO_CTRL_ADDR ##1 reg_rd
            && reg_addr == ILO_CTRL_ADDR
        |=> reg_rdata == ($past(reg_wdata, 2) & ILO_CTRL_WMASK))
        else $error("control readback wrong");

    // Release after detection ends, then follow the base code
    sequence s_held;
        ctrl_q[ILO_HOLD_BIT] && detection_running;
    endsequence

    sequence s_done_plain;
        !detection_running && detected_charger_type < ILO_TYPE_SDP;
    endsequence

    chk_hold_release: assert property (
        s_held ##1 s_done_plain
        |=> input_current_limit_code == $past(base_limit_code))
        else $error("code not released after detection");

    // Hold bit clear: a running detection blocks nothing
    chk_run_no_block: assert property (
        !ctrl_q[ILO_HOLD_BIT] && detection_running
            && detected_charger_type < ILO_TYPE_SDP
        |=> input_current_limit_code == $past(base_limit_code))
        else $error("running detection blocked update");

    // No charger type: base code passes whatever the caps say
    chk_type_none: assert property (
        s_free and (detected_charger_type < ILO_TYPE_SDP)
        |=> input_current_limit_code == $past(base_limit_code))
        else $error("code rewritten with no charger");

    // Control write lands whole, reserved bits dropped
    chk_write_lands: assert property (
        reg_wr && reg_addr == ILO_CTRL_ADDR
        |=> ctrl_q == ($past(reg_wdata) & ILO_CTRL_WMASK))
        else $error("control write lost");

    // Writes elsewhere, status included, leave control alone
    chk_status_ro: assert property (
        reg_wr && reg_addr != ILO_CTRL_ADDR
        |=> $stable(ctrl_q))
        else $error("control changed by stray write");

    // Reserved control bits always read back as zero
    chk_reserved_zero: assert property (
        reg_rd && reg_addr == ILO_CTRL_ADDR
        |=> (reg_rdata & ~ILO_CTRL_WMASK) == ILO_RDATA_IDLE)
        else $error("reserved control bits set");

    // Answer stands one cycle, idle otherwise
    chk_rdata_idle: assert property (
        !reg_rd
        |=> reg_rdata == ILO_RDATA_IDLE)
        else $error("read data without a read");
endmodule

//--- input_current_limit_override_tb_top.sv
// Self-checking bench for the input current limit override block.
// Assumes the register strobes and the limit path timing of the design.
`timescale 1ns/1ns
module input_current_limit_override_tb_top
    import ilo_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [6:0] base_limit_code = 7'h00;
    logic [1:0] detected_charger_type = 2'h0;
    logic [2:0] prior_charger_type = 3'h0;
    logic detection_running = 1'b0;
    logic [6:0] input_current_limit_code;
    logic [6:0] exp_code;
    logic [7:0] rv;
    logic [6:0] sdp_code [4] = '{7'h55, ILO_CODE_500MA, ILO_CODE_1A0,
        ILO_CODE_1A5};
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    ilo_override DUT (
        .core_clk(core_clk),
        .rstn(rstn),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .base_limit_code(base_limit_code),
        .detected_charger_type(detected_charger_type),
        .prior_charger_type(prior_charger_type),
        .detection_running(detection_running),
        .input_current_limit_code(input_current_limit_code)
    );

    // ********************
    // Clock, timeout and helpers
    // ********************
    always #20 core_clk = ~core_clk;

    // Cut a hang short
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test;
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, want);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1 reg_rd = 1'b0;
        v = reg_rdata;
    endtask

    task automatic wait2;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic finish_test;
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ********************
    // Main sequence
    // ********************
    initial begin
        repeat (4) @(posedge core_clk);
        #1 rstn = 1'b1;
        chk({1'b0, input_current_limit_code}, 8'h00);
        chk(reg_rdata, ILO_RDATA_IDLE);
        rd_reg(ILO_CTRL_ADDR, rv);
        chk(rv, ILO_CTRL_RESET);
        // Reserved bits, read-only status and unmapped places
        wr_reg(ILO_CTRL_ADDR, 8'hff);
        rd_reg(ILO_CTRL_ADDR, rv);
        chk(rv, 8'h0f);
        wr_reg(ILO_STATUS_ADDR, 8'hff);
        rd_reg(ILO_STATUS_ADDR, rv);
        chk(rv, 8'h00);
        #40 chk(reg_rdata, 8'h00);
        rd_reg(8'h55, rv);
        chk(rv, 8'h00);
        // Every cap setting against every charger type
        base_limit_code = 7'h55;
        for (int c = 0; c < 16; c += 2) begin
            wr_reg(ILO_CTRL_ADDR, 8'(c));
            for (int t = 0; t < 4; t++) begin
                detected_charger_type = 2'(t);
                prior_charger_type = 3'(c / 2);
                wait2;
                exp_code = (c[3] && t >= 2) ? ILO_CODE_1A5 :
                    (c[2:1] != 0 && t >= 1) ? sdp_code[c[2:1]] : 7'h55;
                chk({1'b0, input_current_limit_code}, {1'b0, exp_code});
                rd_reg(ILO_STATUS_ADDR, rv);
                chk(rv, {1'b0, exp_code});
            end
        end
        // Hold bit freezes the code while detection runs
        wr_reg(ILO_CTRL_ADDR, 8'h00);
        detected_charger_type = 2'h0;
        base_limit_code = 7'h22;
        wait2;
        wr_reg(ILO_CTRL_ADDR, 8'h01);
        detection_running = 1'b1;
        base_limit_code = 7'h33;
        wait2;
        wait2;
        chk({1'b0, input_current_limit_code}, 8'h22);
        detection_running = 1'b0;
        wait2;
        chk({1'b0, input_current_limit_code}, 8'h33);
        // Hold clear passes changes while detection runs
        wr_reg(ILO_CTRL_ADDR, 8'h00);
        detection_running = 1'b1;
        base_limit_code = 7'h44;
        wait2;
        chk({1'b0, input_current_limit_code}, 8'h44);
        finish_test;
    end
endmodule
